// ===== rtl/srs_defs.svh
// Register offsets, field positions and bus constants for the result bank
// Function
// (R1) Pressure result is read-only; each new value sets the pressure-fresh flag.
// (R2) Temperature result is read-only; each new value sets the temperature-fresh flag.
// (R3) Both results are meaningless until the first measurements are transferred.
// (R4) A failed configuration-memory check blocks every result update.
// (R5) Host trusts results only after both fresh flags have been seen set.
// (R6) Host must not use a fixed power-up delay instead of the flags.
// (R7) Snapshot bits 15:5 and 0 mirror the live status at read time.
// (R8) Reading a result copies its fresh flag into snapshot bit 3 or 4.
// (R9) A three-word burst from the temperature address returns both results and snapshot.
// (R10) Status bit 0 reads 0 while busy and 1 while idle.
// (R11) Reading the pressure result clears the pressure-fresh flag.
// (R12) Temperature-fresh sets on update and clears when the temperature result is read.
// (R13) A bridge supply failure sets event bit 7.
// (R14) A sensor bridge check failure sets event bit 8.
// (R15) Status bit 10 shows a saturated computation behind the current results.
// (R16) Pressure update while its fresh flag is set raises event bit 14.
// (R17) Temperature update while its fresh flag is set raises event bit 15.
// (R18) Events stay until one is written to them in live status, not snapshot.
// (R19) Writing all ones to live status clears all events together.
// (R20) Status-type bits follow their hardware condition directly.
// (R21) Serial number is two read-only words, low word then high word.
// (R22) Every register except live status and command ignores writes.
// (R23) Registers are reached only through the serial interface by the master.
// (R24) An event arriving with its clear in the same cycle stays set.
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

`define SRS_OFF_TEMP      8'h2e
`define SRS_OFF_PRES      8'h30
`define SRS_OFF_SNAP      8'h32
`define SRS_OFF_LIVE      8'h36
`define SRS_OFF_SER_LO    8'h50
`define SRS_OFF_SER_HI    8'h52
`define SRS_ADDR_STEP     8'h02

`define SRS_BIT_IDLE      0
`define SRS_BIT_P_FRESH   3
`define SRS_BIT_T_FRESH   4
`define SRS_BIT_BSF       7
`define SRS_BIT_BCF       8
`define SRS_BIT_SAT       10
`define SRS_BIT_COM_CRC   11
`define SRS_BIT_P_MISSED  14
`define SRS_BIT_T_MISSED  15

`define SRS_EVENT_MASK    16'hcb9e
`define SRS_SNAP_LIVE     16'hffe1
`define SRS_FLAGS_RST     16'h0000
`define SRS_RESULT_RST    16'h0000
`define SRS_WORD_ZERO     16'h0000
`define SRS_BYTE_ZERO     8'h00

`define SRS_BITS_PER_BYTE 4'h8
`define SRS_IDX_DEV       2'h0
`define SRS_IDX_MEM       2'h1
`define SRS_IDX_DATA      2'h2
`define SRS_DEV_ADDR      7'h6d

`endif

// ===== rtl/srs_pkg.sv
// Types shared by the result and status register bank
`default_nettype none

package srs_pkg;

	typedef logic [15:0] srs_word_t;
	typedef logic [7:0]  srs_byte_t;

	typedef enum logic [2:0] {
		SRS_IDLE   = 3'b000,
		SRS_RX     = 3'b001,
		SRS_RX_ACK = 3'b010,
		SRS_TX     = 3'b011,
		SRS_TX_ACK = 3'b100
	} srs_state_e;

endpackage : srs_pkg

`default_nettype wire

// ===== rtl/srs_pin_sync.sv
// Two-flop synchroniser with edge detection for the serial pins
`timescale 1ns/1ps
`default_nettype none

module srs_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_i,   // System clock
	input  wire logic         rst_i,   // Async reset, active high
	input  wire logic [W-1:0] pin_i,   // Asynchronous pin levels
	output logic      [W-1:0] level_o, // Synchronised level
	output logic      [W-1:0] rise_o,  // One-cycle rising edge
	output logic      [W-1:0] fall_o   // One-cycle falling edge
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// Pins idle high on an open-drain bus, so reset to ones
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~prev_q;
	assign fall_o  = ~sync_q & prev_q;

endmodule : srs_pin_sync

`default_nettype wire

// ===== rtl/srs_regs.sv
// Result, status, snapshot and serial registers behind a serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "srs_defs.svh"

module srs_regs
	import srs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `SRS_DEV_ADDR
) (
	input  wire logic        clk_i,                    // System clock
	input  wire logic        rst_i,                    // Async reset
	input  wire logic        scl_i,                    // Serial clock pin
	input  wire logic        sda_i,                    // Serial data pin
	output logic             sda_o,                    // Data drive value
	output logic             sda_oe_o,                 // Pull data low
	input  wire logic        meas_t_valid_i,           // New temperature
	input  wire logic [15:0] meas_t_i,                 // Temperature value
	input  wire logic        meas_p_valid_i,           // New pressure
	input  wire logic [15:0] meas_p_i,                 // Pressure value
	input  wire logic        config_memory_crc_fail_i, // Config check failed
	input  wire logic        busy_i,                   // Chip is busy
	input  wire logic        bridge_supply_fault_i,    // Supply fault pulse
	input  wire logic        bridge_check_fault_i,     // Bridge fault pulse
	input  wire logic        dsp_saturated_i,          // Saturation level
	input  wire logic        com_crc_error_i,          // Comm CRC error pulse
	input  wire logic [31:0] serial_number_i           // Chip serial number
);

	logic [1:0] pin_level;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;

	srs_pin_sync #(
		.W (2)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   ({scl_i, sda_i}),
		.level_o (pin_level),
		.rise_o  (pin_rise),
		.fall_o  (pin_fall)
	);

	logic scl_lvl;
	logic sda_lvl;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_lvl   = pin_level[1];
	assign sda_lvl   = pin_level[0];
	assign scl_rise  = pin_rise[1];
	assign scl_fall  = pin_fall[1];
	// Data moving while the clock is high frames a transfer
	assign start_det = pin_fall[0] & scl_lvl;
	assign stop_det  = pin_rise[0] & scl_lvl;

	srs_state_e state_q;
	srs_state_e state_d;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic [1:0] byte_idx_q;
	logic [1:0] byte_idx_d;
	logic       rw_q;
	logic       rw_d;
	logic       hi_phase_q;
	logic       hi_phase_d;
	logic       sda_oe_q;
	logic       sda_oe_d;
	srs_byte_t  addr_q;
	srs_byte_t  addr_d;
	srs_byte_t  shift_q;
	srs_byte_t  shift_d;
	srs_byte_t  hold_q;
	srs_byte_t  hold_d;
	srs_word_t  temp_q;
	srs_word_t  temp_d;
	srs_word_t  pres_q;
	srs_word_t  pres_d;
	srs_word_t  ev_q;
	srs_word_t  ev_d;
	logic [1:0] snap_q;
	logic [1:0] snap_d;

	srs_word_t  live_view;
	srs_word_t  snap_view;

	// Status-type bits are wired straight from their conditions
	always_comb begin
		live_view                  = ev_q;
		live_view[`SRS_BIT_IDLE]   = ~busy_i;          // [R10] [R20]
		live_view[`SRS_BIT_SAT]    = dsp_saturated_i;  // [R15] [R20]
	end

	always_comb begin
		snap_view                   = live_view & `SRS_SNAP_LIVE; // [R7]
		snap_view[`SRS_BIT_P_FRESH] = snap_q[0];
		snap_view[`SRS_BIT_T_FRESH] = snap_q[1];
	end

	// Read mux; unmapped addresses return zero
	function automatic srs_word_t read_word(
		input srs_byte_t a,
		input srs_word_t t,
		input srs_word_t p,
		input srs_word_t live,
		input srs_word_t snap,
		input logic [31:0] ser
	);
		srs_word_t w;
		w = `SRS_WORD_ZERO;
		if (a == `SRS_OFF_TEMP) begin
			w = t;
		end else if (a == `SRS_OFF_PRES) begin
			w = p;
		end else if (a == `SRS_OFF_SNAP) begin
			w = snap;
		end else if (a == `SRS_OFF_LIVE) begin
			w = live;
		end else if (a == `SRS_OFF_SER_LO) begin
			w = ser[15:0];                              // [R21]
		end else if (a == `SRS_OFF_SER_HI) begin
			w = ser[31:16];                             // [R21]
		end
		return w;
	endfunction : read_word

	logic      load_req;
	logic      rd_temp;
	logic      rd_pres;
	logic      wr_live;
	srs_word_t wr_data;
	srs_word_t rd_word;
	srs_byte_t tx_byte;
	logic      t_upd;
	logic      p_upd;
	srs_word_t ev_set;
	srs_word_t ev_clr;

	// Serial slave: byte framing, acknowledge and word assembly
	always_comb begin
		state_d    = state_q;
		bit_cnt_d  = bit_cnt_q;
		byte_idx_d = byte_idx_q;
		rw_d       = rw_q;
		hi_phase_d = hi_phase_q;
		sda_oe_d   = sda_oe_q;
		addr_d     = addr_q;
		shift_d    = shift_q;
		hold_d     = hold_q;
		load_req   = 1'b0;
		wr_live    = 1'b0;
		wr_data    = {shift_q, hold_q};
		rd_temp    = 1'b0;
		rd_pres    = 1'b0;
		rd_word    = `SRS_WORD_ZERO;
		tx_byte    = `SRS_BYTE_ZERO;
		case (state_q)
			SRS_IDLE: begin
				sda_oe_d = 1'b0;
			end
			SRS_RX: begin
				if (scl_rise) begin
					shift_d   = {shift_q[6:0], sda_lvl};
					bit_cnt_d = bit_cnt_q + 4'h1;
				end else if (scl_fall && bit_cnt_q == `SRS_BITS_PER_BYTE) begin
					bit_cnt_d = '0;
					state_d   = SRS_RX_ACK;
					sda_oe_d  = 1'b1;
					if (byte_idx_q == `SRS_IDX_DEV) begin
						rw_d       = shift_q[0];
						byte_idx_d = `SRS_IDX_MEM;
						if (shift_q[7:1] != DEV_ADDR) begin
							sda_oe_d = 1'b0;
							state_d  = SRS_IDLE;
						end
					end else if (byte_idx_q == `SRS_IDX_MEM) begin
						addr_d     = shift_q;
						hi_phase_d = 1'b0;
						byte_idx_d = `SRS_IDX_DATA;
					end else if (!hi_phase_q) begin
						hold_d     = shift_q;
						hi_phase_d = 1'b1;
					end else begin
						// Protected words are acknowledged but dropped
						wr_live    = (addr_q == `SRS_OFF_LIVE); // [R22] [R18]
						hi_phase_d = 1'b0;
						addr_d     = addr_q + `SRS_ADDR_STEP;
					end
				end
			end
			SRS_RX_ACK: begin
				if (scl_fall) begin
					if (rw_q) begin
						load_req = 1'b1;
					end else begin
						sda_oe_d = 1'b0;
						state_d  = SRS_RX;
					end
				end
			end
			SRS_TX: begin
				if (scl_rise) begin
					bit_cnt_d = bit_cnt_q + 4'h1;
				end else if (scl_fall) begin
					if (bit_cnt_q == `SRS_BITS_PER_BYTE) begin
						sda_oe_d = 1'b0;
						state_d  = SRS_TX_ACK;
					end else begin
						shift_d  = {shift_q[6:0], 1'b0};
						sda_oe_d = ~shift_q[6];
					end
				end
			end
			SRS_TX_ACK: begin
				// Master not acknowledging ends the burst
				if (scl_rise && sda_lvl) begin
					state_d = SRS_IDLE;
				end else if (scl_fall) begin
					load_req = 1'b1;
				end
			end
			default: begin
				state_d = SRS_IDLE;
			end
		endcase

		// Low byte fetches the word and fires read effects; address steps
		// by one word, which gives the three-word burst from temperature.
		if (load_req) begin
			if (!hi_phase_q) begin
				rd_word = read_word(addr_q, temp_q, pres_q, live_view,
					snap_view, serial_number_i);
				tx_byte    = rd_word[7:0];
				hold_d     = rd_word[15:8];
				hi_phase_d = 1'b1;
				rd_temp    = (addr_q == `SRS_OFF_TEMP);     // [R9]
				rd_pres    = (addr_q == `SRS_OFF_PRES);     // [R9]
			end else begin
				tx_byte    = hold_q;
				hi_phase_d = 1'b0;
				addr_d     = addr_q + `SRS_ADDR_STEP;       // [R9]
			end
			shift_d   = tx_byte;
			sda_oe_d  = ~tx_byte[7];
			bit_cnt_d = '0;
			state_d   = SRS_TX;
		end

		// Framing overrides whatever the byte engine was doing
		if (start_det) begin
			state_d    = SRS_RX;
			bit_cnt_d  = '0;
			byte_idx_d = `SRS_IDX_DEV;
			hi_phase_d = 1'b0;
			sda_oe_d   = 1'b0;
		end else if (stop_det) begin
			state_d  = SRS_IDLE;
			sda_oe_d = 1'b0;
		end
	end

	// Results, events and snapshot bits
	always_comb begin
		// A failed configuration check freezes both results while its input stays high
		t_upd  = meas_t_valid_i & ~config_memory_crc_fail_i; // [R4]
		p_upd  = meas_p_valid_i & ~config_memory_crc_fail_i; // [R4]
		temp_d = t_upd ? meas_t_i : temp_q;                  // [R2] [R3]
		pres_d = p_upd ? meas_p_i : pres_q;                  // [R1] [R3]

		ev_set                    = `SRS_WORD_ZERO;
		ev_set[`SRS_BIT_P_FRESH]  = p_upd;                              // [R1]
		ev_set[`SRS_BIT_T_FRESH]  = t_upd;                              // [R12]
		ev_set[`SRS_BIT_BSF]      = bridge_supply_fault_i;              // [R13]
		ev_set[`SRS_BIT_BCF]      = bridge_check_fault_i;               // [R14]
		ev_set[`SRS_BIT_COM_CRC]  = com_crc_error_i;
		ev_set[`SRS_BIT_P_MISSED] = p_upd & ev_q[`SRS_BIT_P_FRESH];     // [R16]
		ev_set[`SRS_BIT_T_MISSED] = t_upd & ev_q[`SRS_BIT_T_FRESH];     // [R17]

		ev_clr                    = wr_live ? wr_data : `SRS_WORD_ZERO; // [R19]
		ev_clr[`SRS_BIT_P_FRESH]  = ev_clr[`SRS_BIT_P_FRESH] | rd_pres; // [R11]
		ev_clr[`SRS_BIT_T_FRESH]  = ev_clr[`SRS_BIT_T_FRESH] | rd_temp; // [R12]

		// Set beats clear so a coincident event survives
		ev_d = ((ev_q & ~ev_clr) | ev_set) & `SRS_EVENT_MASK;    // [R18] [R24]

		snap_d = snap_q;
		if (rd_pres) begin
			snap_d[0] = ev_q[`SRS_BIT_P_FRESH];                  // [R8]
		end
		if (rd_temp) begin
			snap_d[1] = ev_q[`SRS_BIT_T_FRESH];                  // [R8]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q    <= SRS_IDLE;
			bit_cnt_q  <= '0;
			byte_idx_q <= `SRS_IDX_DEV;
			rw_q       <= 1'b0;
			hi_phase_q <= 1'b0;
			sda_oe_q   <= 1'b0;
			addr_q     <= `SRS_BYTE_ZERO;
			shift_q    <= `SRS_BYTE_ZERO;
			hold_q     <= `SRS_BYTE_ZERO;
			temp_q     <= `SRS_RESULT_RST;
			pres_q     <= `SRS_RESULT_RST;
			ev_q       <= `SRS_FLAGS_RST;
			snap_q     <= '0;
		end else begin
			state_q    <= state_d;
			bit_cnt_q  <= bit_cnt_d;
			byte_idx_q <= byte_idx_d;
			rw_q       <= rw_d;
			hi_phase_q <= hi_phase_d;
			sda_oe_q   <= sda_oe_d;
			addr_q     <= addr_d;
			shift_q    <= shift_d;
			hold_q     <= hold_d;
			temp_q     <= temp_d;
			pres_q     <= pres_d;
			ev_q       <= ev_d;
			snap_q     <= snap_d;
		end
	end

	// Open drain: the line is only ever pulled low
	assign sda_o    = 1'b0; // [R23]
	assign sda_oe_o = sda_oe_q;

endmodule : srs_regs

`default_nettype wire

// ===== test/srs_regs_props.sv
// Pin-level assertions for the result and status register bank
`timescale 1ns/1ps
`default_nettype none

module srs_regs_props (
	input wire logic clk_i,   // System clock
	input wire logic rst_i,   // Async reset
	input wire logic scl_i,   // Serial clock pin
	input wire logic sda_i,   // Serial data pin
	input wire logic sda_o,   // Data drive value
	input wire logic sda_oe_o // Pull data low
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic [7:0] hold_q;
	logic [7:0] hold_d;

	// Longest legal pull is an ACK plus eight zero bits
	always_comb begin
		hold_d = sda_oe_o ? hold_q + 8'h01 : 8'h00;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			hold_q <= 8'h00;
		else
			hold_q <= hold_d;
	end

	chk_drive_low: assert property (sda_o == 1'b0)
		else $error("data drive value not low");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !sda_oe_o)
		else $error("data pulled right after reset");
	chk_change_low: assert property (
		$changed(sda_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2))
		else $error("data drive changed outside clock low");
	chk_high_stable: assert property (
		scl_i [*3] |-> $stable(sda_oe_o))
		else $error("data drive moved while clock high");
	chk_pull_holds: assert property (
		$rose(sda_oe_o) |-> sda_oe_o [*8])
		else $error("data pull too short");
	chk_free_holds: assert property (
		$fell(sda_oe_o) |-> !sda_oe_o [*8])
		else $error("data release too short");
	chk_start_quiet: assert property (
		scl_i && $fell(sda_i) |-> !sda_oe_o [*8])
		else $error("device drove data during start");
	chk_pull_bound: assert property (hold_q < 8'h7d)
		else $error("data held low too long");

	cov_pull: cover property ($rose(sda_oe_o));
	cov_start: cover property (scl_i && $fell(sda_i));
	cov_long: cover property (hold_q == 8'h40);

endmodule : srs_regs_props

bind srs_regs srs_regs_props u_srs_regs_props (
	.clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o
);

`default_nettype wire

// ===== test/srs_host.sv
// Serial bus master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none

module srs_host #(
	parameter logic [6:0] DEV = 7'h6d
) (
	output logic      scl_o,    // Serial clock, high when idle
	output logic      sda_oe_o, // Pull data line low
	input  wire logic sda_i     // Resolved data line
);
	localparam realtime Q = 31.25;

	logic [15:0] rdat [3];
	int          nak = 0;
	logic [6:0]  dev_sel = DEV; // Address sent; bench may aim it elsewhere

	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	// Data moves a quarter period after the fall, clear of the device hold
	task automatic put(input logic v);
		sda_oe_o = ~v;
		#Q scl_o = 1'b1;
		#(2*Q) scl_o = 1'b0;
		#Q;
	endtask : put

	task automatic get(output logic v);
		sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q v = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask : get

	task automatic start;
		sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask : start

	task automatic stop;
		sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#(2*Q);
	endtask : stop

	task automatic tx(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(a);
		if (a)
			nak++;
	endtask : tx

	task automatic rx(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(last);
	endtask : rx

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		start();
		tx({dev_sel, 1'b0});
		tx(a);
		tx(d[7:0]);
		tx(d[15:8]);
		stop();
	endtask : wr

	task automatic rd(input logic [7:0] a, input int n);
		start();
		tx({dev_sel, 1'b0});
		tx(a);
		start();
		tx({dev_sel, 1'b1});
		for (int w = 0; w < n; w++) begin
			rx(1'b0, rdat[w][7:0]);
			rx(w == n - 1, rdat[w][15:8]);
		end
		stop();
	endtask : rd

endmodule : srs_host

`default_nettype wire

// ===== test/sensor_result_status_regs_bench.sv
// Self-checking bench for the result and status register bank
`timescale 1ns/1ps
`default_nettype none

module sensor_result_status_regs_bench;
	import srs_pkg::*;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        crc   = 1'b1;
	logic        busy  = 1'b1;
	logic        sat   = 1'b0;
	logic [4:0]  ev    = 5'h00;
	srs_word_t   tval  = 16'h1234;
	srs_word_t   pval  = 16'habcd;
	logic [31:0] ser   = 32'h5a3c_0f96;
	wire         scl;
	wire         h_oe;
	wire         d_oe;
	wire         sda = ~(h_oe | d_oe);
	int          bad_count = 0;
	int          comparisons = 0;

	always #5 clk_i = ~clk_i;

	srs_regs u_srs_regs (
		.clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(d_oe),
		.meas_t_valid_i(ev[0]), .meas_t_i(tval), .meas_p_valid_i(ev[1]),
		.meas_p_i(pval), .config_memory_crc_fail_i(crc), .busy_i(busy),
		.bridge_supply_fault_i(ev[2]), .bridge_check_fault_i(ev[3]),
		.dsp_saturated_i(sat), .com_crc_error_i(ev[4]),
		.serial_number_i(ser)
	);

	srs_host u_srs_host (.scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda));

	task automatic tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input srs_word_t got, input srs_word_t exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdc(input srs_byte_t a, input int n, input srs_word_t e0,
		input srs_word_t e1 = 16'h0000, input srs_word_t e2 = 16'h0000);
		u_srs_host.rd(a, n);
		chk(u_srs_host.rdat[0], e0);
		if (n > 1)
			chk(u_srs_host.rdat[1], e1);
		if (n > 2)
			chk(u_srs_host.rdat[2], e2);
	endtask : rdc

	// One-cycle pulses on measurement and fault inputs
	task automatic pls(input logic [4:0] m);
		@(posedge clk_i) ev <= m;
		@(posedge clk_i) ev <= 5'h00;
	endtask : pls

	initial begin
		#1ms;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdc(8'h36, 1, 16'h0000);
		rdc(8'h50, 2, ser[15:0], ser[31:16]);
		rdc(8'h40, 1, 16'h0000);
		pls(5'h03);
		@(posedge clk_i) {crc, busy} <= 2'b00;
		rdc(8'h2e, 3, 16'h0000, 16'h0000, 16'h0001);
		pls(5'h03);
		rdc(8'h2e, 3, tval, pval, 16'h0019);
		rdc(8'h36, 1, 16'h0001);
		pls(5'h03);
		pls(5'h03);
		rdc(8'h36, 1, 16'hc019);
		@(posedge clk_i) sat <= 1'b1;
		pls(5'h1c);
		rdc(8'h36, 1, 16'hcd99);
		rdc(8'h32, 1, 16'hcd99);
		// A clear sent to another device address must be ignored
		u_srs_host.dev_sel = 7'h2a;
		u_srs_host.wr(8'h36, 16'hffff);
		u_srs_host.dev_sel = 7'h6d;
		rdc(8'h36, 1, 16'hcd99);
		u_srs_host.wr(8'h32, 16'hffff);
		rdc(8'h36, 1, 16'hcd99);
		// The 36th clock fall ends the high data byte; the fault pulse
		// is timed to hit the very cycle that applies the clear
		fork
			u_srs_host.wr(8'h36, 16'h0080);
			begin
				repeat (36) @(negedge scl);
				repeat (2) @(posedge clk_i);
				ev <= 5'h04;
				@(posedge clk_i) ev <= 5'h00;
			end
		join
		rdc(8'h36, 1, 16'hcd99);
		u_srs_host.wr(8'h36, 16'h0080);
		rdc(8'h36, 1, 16'hcd19);
		@(posedge clk_i) sat <= 1'b0;
		rdc(8'h36, 1, 16'hc919);
		u_srs_host.wr(8'h36, 16'hffff);
		rdc(8'h36, 1, 16'h0001);
		@(posedge clk_i) busy <= 1'b1;
		rdc(8'h36, 1, 16'h0000);
		u_srs_host.wr(8'h2e, 16'h5555);
		u_srs_host.wr(8'h50, 16'h5555);
		rdc(8'h2e, 2, tval, pval);
		rdc(8'h50, 1, ser[15:0]);
		chk(16'(u_srs_host.nak), 16'h0004);
		tally_and_finish();
	end

endmodule : sensor_result_status_regs_bench

`default_nettype wire
